// ### cmd_half_decode.sv
module cmd_half_decode
  import launch_pkg::*;
(
  input  wire logic [HALF_W-1:0] half,
  output cmd_t                   cmd
);

  logic [ARM_W-1:0]  arm;
  logic [ORD_W-1:0]  ord;
  logic [DATA_W-1:0] data;
  logic              clash;
  logic              relay_ok;
  cmd_kind_t         kind;

  assign arm  = half[ARM_LSB +: ARM_W];
  assign ord  = half[ORD_LSB +: ORD_W];
  assign data = half[DATA_W-1:0];
  assign clash = (arm != '0) && (ord != '0);
  // relay index past the last relay addresses no launcher
  assign relay_ok =
    data[REL_LSB +: REL_W] < REL_W'(NUM_RELAYS);

  // same payload, armament code in place of ordnance code
  assign kind =
    clash                  ? CK_NONE :
    arm == ARM_TUBE_HOLD   ? (relay_ok ? CK_TUBE_HOLD : CK_NONE) :
    arm == ARM_TUBE_INTG   ? CK_TUBE_INTG :
    arm != '0              ? CK_ARM_INTG :
    ord == ORD_TUBE        ? (relay_ok ? CK_TUBE : CK_NONE) :
    ord == ORD_SUS         ? CK_SUS :
    ord == ORD_SELECT      ? CK_SELECT :
                             CK_NONE;

  assign cmd = '{kind: kind, arm: arm, data: data, clash: clash};

endmodule

// ### cmd_source.sv
module cmd_source
  import launch_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              cmd_request,
  output logic [WORD_W-1:0]      cmd_word,
  output logic                   ef_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_word  = 30'h2aaaaaaa;
    ef_strobe = 1'b0;
  end
  // flip injects a computer fault; gap makes the source slow
  task automatic send(input logic [14:0] h, input logic [29:0] flip,
                      input int gap, output bit hung);
    int k;
    repeat (gap) @(posedge aclk);
    @(posedge aclk);
    cmd_word  <= {h, h} ^ flip;
    ef_strobe <= 1'b1;
    for (k = 0; k < 2000; k++) begin
      @(posedge aclk);
      if (cmd_request) break;
    end
    hung = (k == 2000);
    ef_strobe <= 1'b0;
    // a released bus must not keep showing the last word
    cmd_word  <= ~({h, h} ^ flip);
  endtask
endmodule

// ### launch_cmd_monitor.sv
module launch_cmd_monitor
  import launch_pkg::*;
#(
  parameter int TUBE_CYC = CYC_TUBE,
  parameter int SUS_CYC  = CYC_SUS,
  parameter int FIRE_CYC = CYC_FIRE
) (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  cmd_request,
  input wire logic                  inhibit,
  input wire logic                  type_one_error,
  input wire logic                  launch_mismatch_error,
  input wire logic                  arm_interrogate,
  input wire logic                  launch_cmd,
  input wire logic [NUM_RELAYS-1:0] relay_sel,
  input wire logic                  tube_interrogate_out,
  input wire logic [2:0]            spare_out,
  input wire logic [1:0]            firing_select,
  input wire logic                  sus_deep,
  input wire logic                  sus_shallow
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [22:0] rel_cnt_r;
  logic [22:0] sus_cnt_r;
  // run lengths in clocks, so long pulses are judged to the cycle
  always_ff @(posedge aclk) begin
    rel_cnt_r <= (|relay_sel) ? rel_cnt_r + 23'h1 : 23'h0;
    sus_cnt_r <= (sus_deep | sus_shallow) ? sus_cnt_r + 23'h1 : 23'h0;
  end
  property p_inhibit;
    inhibit == !cmd_request;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("inhibit not inverse of request");
  property p_word_err;
    $fell(type_one_error) |-> inhibit && $past(type_one_error, 13);
  endproperty
  a_word_err: assert property (p_word_err)
    else $error("word error pulse wrong");
  property p_query;
    $fell(arm_interrogate) |-> !cmd_request && $past(arm_interrogate, 13);
  endproperty
  a_query: assert property (p_query)
    else $error("query pulse wrong");
  property p_no_fire;
    tube_interrogate_out |-> firing_select == 2'b00;
  endproperty
  a_no_fire: assert property (p_no_fire)
    else $error("fire select during interrogation");
  property p_spares;
    spare_out == {launch_cmd, launch_cmd, 1'b0};
  endproperty
  a_spares: assert property (p_spares)
    else $error("spares differ from launch");
  property p_busy;
    (launch_cmd | sus_deep | sus_shallow) |-> !cmd_request;
  endproperty
  a_busy: assert property (p_busy)
    else $error("request high during launch");
  property p_fire_delay;
    $rose(launch_cmd) |-> rel_cnt_r == FIRE_CYC && $onehot(relay_sel);
  endproperty
  a_fire_delay: assert property (p_fire_delay)
    else $error("fire delay wrong");
  property p_tube_len;
    $fell(|relay_sel) && $past(launch_cmd) |-> rel_cnt_r == TUBE_CYC;
  endproperty
  a_tube_len: assert property (p_tube_len)
    else $error("tube select length wrong");
  property p_sus_len;
    $fell(sus_deep | sus_shallow) |-> sus_cnt_r == SUS_CYC;
  endproperty
  a_sus_len: assert property (p_sus_len)
    else $error("store launch length wrong");
  property p_lm;
    launch_mismatch_error |-> inhibit;
  endproperty
  a_lm: assert property (p_lm)
    else $error("launch mismatch outside inhibit");
endmodule

// ### launch_pkg.sv
package launch_pkg;

  localparam int HALF_W   = 15;
  localparam int WORD_W   = 30;
  localparam int ARM_LSB  = 12;
  localparam int ARM_W    = 3;
  localparam int ORD_LSB  = 8;
  localparam int ORD_W    = 4;
  localparam int DATA_W   = 8;
  localparam int REL_LSB  = 0;
  localparam int REL_W    = 4;
  localparam int LEFT_BIT = 4;
  localparam int EVEN_BIT = 5;
  localparam int ALT_BIT  = 6;
  localparam int DEEP_BIT = 0;
  localparam int SHAL_BIT = 1;
  localparam int NUM_RELAYS = 13;

  // ordnance codes, pairwise distance two
  localparam logic [ORD_W-1:0] ORD_TUBE   = 4'h3;
  localparam logic [ORD_W-1:0] ORD_SUS    = 4'h5;
  localparam logic [ORD_W-1:0] ORD_SELECT = 4'h6;
  localparam logic [ARM_W-1:0] ARM_TUBE_INTG = 3'h1;
  localparam logic [ARM_W-1:0] ARM_TUBE_HOLD = 3'h4;

  localparam longint CLK_HZ         = 25_000_000;
  localparam longint T_SUS_MS       = 130;
  localparam longint T_TUBE_MS      = 260;
  localparam longint T_FIRE_MS      = 130;
  localparam longint T_SEL_LOCK_MS  = 130;
  localparam longint T_PULSE_NS     = 500;
  localparam longint T_INTG_LOCK_NS = 1000;

  localparam int CYC_SUS  = int'(T_SUS_MS * CLK_HZ / 1000);
  localparam int CYC_TUBE = int'(T_TUBE_MS * CLK_HZ / 1000);
  localparam int CYC_FIRE = int'(T_FIRE_MS * CLK_HZ / 1000);
  localparam int CYC_SEL_LOCK = int'(T_SEL_LOCK_MS * CLK_HZ / 1000);
  localparam int CYC_PULSE =
    int'((T_PULSE_NS * CLK_HZ + 999_999_999) / 1_000_000_000);
  localparam int CYC_INTG_LOCK =
    int'((T_INTG_LOCK_NS * CLK_HZ + 999_999_999) / 1_000_000_000);
  localparam int PULSE_W = 5;

  localparam int             ADDR_W      = 8;
  localparam logic [7:0]     ADDR_CTRL   = 8'h00;
  localparam logic [7:0]     ADDR_STATUS = 8'h04;
  localparam logic [7:0]     ADDR_LAUNCH = 8'h08;
  localparam logic           CTRL_EN_RST = 1'b1;
  localparam int             CTRL_EN_BIT = 0;
  localparam logic [1:0]     RESP_OKAY   = 2'h0;
  localparam logic [1:0]     RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CK_NONE, CK_TUBE, CK_SUS, CK_SELECT,
    CK_TUBE_HOLD, CK_TUBE_INTG, CK_ARM_INTG
  } cmd_kind_t;

  typedef struct packed {
    cmd_kind_t          kind;
    logic [ARM_W-1:0]   arm;
    logic [DATA_W-1:0]  data;
    logic               clash;
  } cmd_t;

  typedef struct packed {
    logic              active;
    logic              tube;
    logic              hold;
    logic [REL_W-1:0]  relay;
    logic              left;
    logic              even;
    logic              alt;
    logic              deep;
    logic              shallow;
  } launch_t;

  typedef struct packed {
    logic                   launch;
    logic                   left;
    logic                   alt;
    logic [NUM_RELAYS-1:0]  relay;
    logic                   even;
    logic                   tube_intg;
    logic [2:0]             spare;
    logic [1:0]             fire;
    logic                   deep;
    logic                   shallow;
  } drive_t;

  typedef struct packed {
    logic [17:0]        zero;
    logic               hold;
    logic               aint;
    logic               request;
    logic               launch_err;
    logic               status_err;
    logic               word_err;
    logic [DATA_W-1:0]  status;
  } stat_word_t;

  typedef struct packed {
    logic [19:0]  zero;
    launch_t      launch;
  } launch_word_t;

endpackage

// ### redundant_launch_command_logic.sv
// The AXI4-Lite slave port and the register offsets were left to the implementer.
module redundant_launch_command_logic
  import launch_pkg::*;
#(
  parameter int TUBE_CYC = CYC_TUBE,
  parameter int SUS_CYC  = CYC_SUS,
  parameter int FIRE_CYC = CYC_FIRE,
  parameter int SEL_CYC  = CYC_SEL_LOCK,
  parameter int CNT_W    = 23
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [WORD_W-1:0] cmd_word,
  input  wire logic              ef_strobe,
  output logic                   cmd_request,
  output logic                   inhibit,
  output logic                   type_one_error,
  output logic                   status_mismatch_error,
  output logic                   launch_mismatch_error,
  output logic                   arm_interrogate,
  output logic [ARM_W-1:0]       arm_interrogate_code,
  output logic                   launch_cmd,
  output logic                   left_bank_sel,
  output logic                   alt_driver_sel,
  output logic [NUM_RELAYS-1:0]  relay_sel,
  output logic                   even_sel,
  output logic                   tube_interrogate_out,
  output logic [2:0]             spare_out,
  output logic [1:0]             firing_select,
  output logic                   sus_deep,
  output logic                   sus_shallow,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready
);

  if (TUBE_CYC >= 2 ** CNT_W || SUS_CYC >= TUBE_CYC ||
      FIRE_CYC >= TUBE_CYC || SEL_CYC >= 2 ** CNT_W ||
      CYC_PULSE >= 2 ** PULSE_W) begin : g_chk
    $error("timing parameters do not fit the counters");
  end

  localparam logic [CNT_W-1:0] TUBE_END   = CNT_W'(TUBE_CYC - 1);
  localparam logic [CNT_W-1:0] SUS_END    = CNT_W'(SUS_CYC - 1);
  localparam logic [CNT_W-1:0] FIRE_START = CNT_W'(FIRE_CYC);
  localparam logic [CNT_W-1:0] SEL_LOCK   = CNT_W'(SEL_CYC);
  localparam logic [CNT_W-1:0] INTG_LOCK  = CNT_W'(CYC_INTG_LOCK);
  // one cycle longer than the pulse so its fall lands under inhibit
  localparam logic [CNT_W-1:0] ERR_LOCK   = CNT_W'(CYC_PULSE + 1);
  localparam logic [PULSE_W-1:0] PULSE_LEN = PULSE_W'(CYC_PULSE);

  function automatic launch_t next_launch(
    input launch_t cur,
    input cmd_t    c,
    input logic    ld,
    input logic    done,
    input logic    drop_hold
  );
    launch_t n;
    n = cur;
    if (done || (drop_hold && cur.hold)) begin
      n = '0;
    end
    if (ld) begin
      n         = '0;
      n.relay   = c.data[REL_LSB +: REL_W];
      n.left    = c.data[LEFT_BIT];
      n.even    = c.data[EVEN_BIT];
      n.alt     = c.data[ALT_BIT];
      n.deep    = c.data[DEEP_BIT];
      n.shallow = c.data[SHAL_BIT];
      n.tube    = c.kind == CK_TUBE;
      n.hold    = c.kind == CK_TUBE_HOLD;
      n.active  = c.kind != CK_TUBE_HOLD;
    end
    return n;
  endfunction

  function automatic logic [NUM_RELAYS-1:0] onehot(
    input logic [REL_W-1:0] idx
  );
    logic [NUM_RELAYS-1:0] v;
    v = '0;
    for (int i = 0; i < NUM_RELAYS; i++) begin
      v[i] = idx == REL_W'(i);
    end
    return v;
  endfunction

  cmd_t                 dec_a;
  cmd_t                 dec_b;
  launch_t              la_r;
  launch_t              lb_r;
  launch_t              la_nxt;
  launch_t              lb_nxt;
  logic [DATA_W-1:0]    sa_r;
  logic [DATA_W-1:0]    sb_r;
  logic [DATA_W-1:0]    sa_nxt;
  logic [DATA_W-1:0]    sb_nxt;
  logic [CNT_W-1:0]     tmr_r;
  logic [CNT_W-1:0]     tmr_nxt;
  logic [CNT_W-1:0]     lock_r;
  logic [CNT_W-1:0]     lock_nxt;
  logic [PULSE_W-1:0]   pulse_r;
  logic [PULSE_W-1:0]   pulse_nxt;
  logic                 err1_r;
  logic                 err1_nxt;
  logic                 aint_r;
  logic                 aint_nxt;
  logic [ARM_W-1:0]     code_r;
  logic [ARM_W-1:0]     code_nxt;
  logic                 sm_r;
  logic                 lm_r;
  logic                 lm_nxt;
  drive_t               drv_r;
  drive_t               drv_nxt;
  logic                 ctrl_en_r;

  cmd_half_decode u_half_a (
    .half (cmd_word[HALF_W-1:0]),
    .cmd  (dec_a)
  );

  cmd_half_decode u_half_b (
    .half (cmd_word[WORD_W-1:HALF_W]),
    .cmd  (dec_b)
  );

  // command acceptance
  wire take = cmd_request & ef_strobe;
  wire halves_differ =
    cmd_word[HALF_W-1:0] != cmd_word[WORD_W-1:HALF_W];
  wire malformed = halves_differ | dec_a.clash | dec_b.clash;
  wire bad_take  = take & malformed;
  wire agree     = dec_a == dec_b;
  wire go        = take & ~malformed & agree;
  wire go_tube   = go & (dec_a.kind == CK_TUBE);
  wire go_sus    = go & (dec_a.kind == CK_SUS);
  wire go_hold   = go & (dec_a.kind == CK_TUBE_HOLD);
  wire go_sel    = go & (dec_a.kind == CK_SELECT);
  wire go_query  = go & ((dec_a.kind == CK_TUBE_INTG) |
                         (dec_a.kind == CK_ARM_INTG));
  wire ld        = go_tube | go_sus | go_hold;

  // launch timing, shared by both halves
  wire running = la_r.active | lb_r.active;
  wire [CNT_W-1:0] lim = la_r.tube ? TUBE_END : SUS_END;
  wire done = running & (tmr_r == lim);
  assign tmr_nxt = (go_tube | go_sus | done | ~running) ? '0 :
                   tmr_r + CNT_W'(1);

  wire pulse_end = pulse_r == PULSE_W'(1);
  // end of the 01 query pulse releases the latched relay matrix
  wire drop_hold = pulse_end & aint_r &
                   (code_r == ARM_TUBE_INTG);

  // each half loads only from its own decoder
  assign la_nxt = next_launch(la_r, dec_a, ld, done, drop_hold);
  assign lb_nxt = next_launch(lb_r, dec_b, ld, done, drop_hold);

  assign sa_nxt = go_sel ? dec_a.data : sa_r;
  assign sb_nxt = go_sel ? dec_b.data : sb_r;

  assign lock_nxt =
    bad_take           ? ERR_LOCK :
    (go_sel | go_hold) ? SEL_LOCK :
    go_query           ? INTG_LOCK :
    (lock_r != '0)     ? lock_r - CNT_W'(1) : '0;

  assign pulse_nxt =
    (bad_take | go_query) ? PULSE_LEN :
    (pulse_r != '0)       ? pulse_r - PULSE_W'(1) : '0;
  assign err1_nxt = bad_take | (err1_r & ~pulse_end);
  assign aint_nxt = go_query | (aint_r & ~pulse_end);
  assign code_nxt = go_query ? dec_a.arm : code_r;

  // falls on the same edge as the launch registers clear
  assign lm_nxt = running & ~done & (la_r != lb_r);

  // each output bit needs both halves to assert it; launch, spare and fire select need them to agree bit for bit
  wire a_tube    = la_r.active & la_r.tube;
  wire b_tube    = lb_r.active & lb_r.tube;
  wire both_tube = a_tube & b_tube;
  wire both_hold = la_r.hold & lb_r.hold;
  wire sel_on    = both_tube | both_hold;
  wire both_sus  = la_r.active & ~la_r.tube &
                   lb_r.active & ~lb_r.tube;
  // hold state never qualifies, so interrogation cannot fire
  wire fire_ok   = both_tube & (tmr_r >= FIRE_START) &
                   (la_r == lb_r);

  assign drv_nxt.relay =
    sel_on ? onehot(la_r.relay) & onehot(lb_r.relay) : '0;
  assign drv_nxt.left  = sel_on & la_r.left & lb_r.left;
  // bank reversal happens in the relay this drives
  assign drv_nxt.alt   = sel_on & la_r.alt & lb_r.alt;
  assign drv_nxt.even  = sel_on & la_r.even & lb_r.even;
  assign drv_nxt.tube_intg = both_hold;
  assign drv_nxt.launch = fire_ok;
  assign drv_nxt.spare = {fire_ok, fire_ok, 1'b0};
  assign drv_nxt.fire  =
    fire_ok ? {la_r.even & lb_r.even,
               ~la_r.even & ~lb_r.even} : 2'b00;
  assign drv_nxt.deep    = both_sus & la_r.deep & lb_r.deep;
  assign drv_nxt.shallow = both_sus & la_r.shallow & lb_r.shallow;

  // software can stop acceptance; lockouts still run out
  // output flops trail the launch regs by a cycle; keep request low then too
  wire busy = running | (lock_r != '0) | (pulse_r != '0) |
              drv_r.launch | drv_r.deep | drv_r.shallow | ~ctrl_en_r;
  assign cmd_request = ~busy;
  assign inhibit     = busy;

  // sync reset clears every launch and error output, well inside 1 ms; cmd_request and the ready outputs come up high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      la_r    <= '0;
      lb_r    <= '0;
      sa_r    <= '0;
      sb_r    <= '0;
      tmr_r   <= '0;
      lock_r  <= '0;
      pulse_r <= '0;
      err1_r  <= 1'b0;
      aint_r  <= 1'b0;
      code_r  <= '0;
      sm_r    <= 1'b0;
      lm_r    <= 1'b0;
      drv_r   <= '0;
    end else begin
      la_r    <= la_nxt;
      lb_r    <= lb_nxt;
      sa_r    <= sa_nxt;
      sb_r    <= sb_nxt;
      tmr_r   <= tmr_nxt;
      lock_r  <= lock_nxt;
      pulse_r <= pulse_nxt;
      err1_r  <= err1_nxt;
      aint_r  <= aint_nxt;
      code_r  <= code_nxt;
      sm_r    <= sa_r != sb_r;
      lm_r    <= lm_nxt;
      drv_r   <= drv_nxt;
    end
  end

  assign type_one_error        = err1_r;
  assign status_mismatch_error = sm_r;
  assign launch_mismatch_error = lm_r;
  assign arm_interrogate       = aint_r;
  assign arm_interrogate_code  = code_r;
  assign launch_cmd            = drv_r.launch;
  assign left_bank_sel         = drv_r.left;
  assign alt_driver_sel        = drv_r.alt;
  assign relay_sel             = drv_r.relay;
  assign even_sel              = drv_r.even;
  assign tube_interrogate_out  = drv_r.tube_intg;
  assign spare_out             = drv_r.spare;
  assign firing_select         = drv_r.fire;
  assign sus_deep              = drv_r.deep;
  assign sus_shallow           = drv_r.shallow;

  // register slave
  logic              aw_r;
  logic              w_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;
  stat_word_t        stat_w;
  launch_word_t      launch_w;

  assign awready = ~aw_r & ~bvalid_r;
  assign wready  = ~w_r & ~bvalid_r;
  assign arready = ~rvalid_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;

  wire aw_hs  = awvalid & awready;
  wire w_hs   = wvalid & wready;
  wire ar_hs  = arvalid & arready;
  wire wr_go  = aw_r & w_r;
  wire wr_ctl = awaddr_r[ADDR_W-1:2] == ADDR_CTRL[ADDR_W-1:2];
  wire [ADDR_W-3:0] rd_idx = araddr[ADDR_W-1:2];
  wire rd_ctl = rd_idx == ADDR_CTRL[ADDR_W-1:2];
  wire rd_sta = rd_idx == ADDR_STATUS[ADDR_W-1:2];
  wire rd_lau = rd_idx == ADDR_LAUNCH[ADDR_W-1:2];
  wire rd_hit = rd_ctl | rd_sta | rd_lau;

  assign stat_w = '{zero: '0, hold: both_hold, aint: aint_r,
                    request: cmd_request, launch_err: lm_r,
                    status_err: sm_r, word_err: err1_r,
                    status: sa_r};
  assign launch_w = '{zero: '0, launch: la_r};

  wire [31:0] rd_word =
    rd_ctl ? {31'h0, ctrl_en_r} :
    rd_sta ? stat_w :
    rd_lau ? launch_w : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_r      <= 1'b0;
      w_r       <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      ctrl_en_r <= CTRL_EN_RST;
    end else begin
      if (aw_hs) begin
        aw_r     <= 1'b1;
        awaddr_r <= awaddr;
      end
      if (w_hs) begin
        w_r     <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
      end
      if (wr_go) begin
        aw_r     <= 1'b0;
        w_r      <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= wr_ctl ? RESP_OKAY : RESP_SLVERR;
        if (wr_ctl && wstrb_r[0]) begin
          ctrl_en_r <= wdata_r[CTRL_EN_BIT];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_word;
      rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule

// ### redundant_launch_command_logic_tb.sv
module redundant_launch_command_logic_tb import launch_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TUBE = 400;
  localparam int SOUND_SIGNAL_STORE  = 200;
  localparam int FIRE = 200;
  localparam int SEL  = 150;
  logic aclk, aresetn, ef_strobe, cmd_request, inhibit, type_one_error;
  logic status_mismatch_error, launch_mismatch_error, arm_interrogate;
  logic launch_cmd, left_bank_sel, alt_driver_sel, even_sel, sus_deep;
  logic tube_interrogate_out, sus_shallow, awvalid, awready, wvalid;
  logic wready, bvalid, bready, arvalid, arready, rvalid, rready, probe;
  logic [WORD_W-1:0]     cmd_word;
  logic [ARM_W-1:0]      arm_interrogate_code;
  logic [NUM_RELAYS-1:0] relay_sel;
  logic [2:0]            spare_out;
  logic [1:0]            firing_select, bresp, rresp;
  logic [ADDR_W-1:0]     awaddr, araddr;
  logic [31:0]           wdata, rdata;
  logic [3:0]            wstrb;
  int                    err_count, checked, psel;
  assign probe = psel == 0 ? sus_deep : psel == 1 ? sus_shallow :
    psel == 2 ? inhibit : psel == 3 ? type_one_error :
    psel == 4 ? arm_interrogate : psel == 5 ? launch_cmd :
    !tube_interrogate_out;
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  redundant_launch_command_logic #(.TUBE_CYC(TUBE), .SUS_CYC(SOUND_SIGNAL_STORE),
    .FIRE_CYC(FIRE), .SEL_CYC(SEL)) u_redundant_launch_command_logic (
    .aclk, .aresetn, .cmd_word, .ef_strobe, .cmd_request, .inhibit,
    .type_one_error, .status_mismatch_error, .launch_mismatch_error,
    .arm_interrogate, .arm_interrogate_code, .launch_cmd, .left_bank_sel,
    .alt_driver_sel, .relay_sel, .even_sel, .tube_interrogate_out,
    .spare_out, .firing_select, .sus_deep, .sus_shallow, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  cmd_source u_cmd_source (.aclk, .cmd_request, .cmd_word, .ef_strobe);
  task close_out;
    if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input bit c, input string m);
    checked++;
    if (!c) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task give_up(input string m);
    chk(1'b0, m);
    close_out;
  endtask
  task upto(input int s);
    int k;
    psel = s;
    // let the take edge settle so a pulse rising on it is counted
    #1;
    for (k = 0; probe !== 1'b1; k++) begin
      if (k == 2000) give_up("wait ran out");
      @(posedge aclk);
      #1;
    end
  endtask
  task run_n(input int n);
    int k;
    for (k = 0; probe === 1'b1 && k < 2000; k++) begin
      @(posedge aclk);
      #1;
    end
    chk(k == n, "pulse length");
  endtask
  task span(input int s, input int n);
    upto(s);
    run_n(n);
  endtask
  task cmd(input logic [14:0] h, input logic [29:0] f, input int g);
    bit hung;
    u_cmd_source.send(h, f, g, hung);
    if (hung) give_up("request never rose");
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (k == 50) give_up("no write answer");
    r = bresp;
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (k == 50) give_up("no read answer");
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task tube(input logic [7:0] d, input logic [12:0] rel, input logic [1:0] fs);
    cmd(15'h0300 | {7'h0, d}, 30'h0, 0);
    repeat (2) begin
      @(posedge aclk);
      #1;
    end
    chk(relay_sel === rel && {alt_driver_sel, left_bank_sel, even_sel}
        === {d[6], d[4], d[5]}, "tube select");
    upto(5);
    chk(firing_select === fs && spare_out === 3'b110, "fire");
    run_n(TUBE - FIRE);
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    err_count = 0;
    checked = 0;
    psel = 0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, wstrb} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk(cmd_request === 1'b1 && inhibit === 1'b0, "idle");
    rd(8'h00, d, r);
    chk(d === 32'h1 && r === RESP_OKAY, "ctrl reset");
    wr(8'h04, 32'h0, r);
    chk(r === RESP_SLVERR, "read-only write");
    rd(8'h0c, d, r);
    chk(d === 32'h0 && r === RESP_SLVERR, "unmapped");
    wr(8'h00, 32'h0, r);
    #1;
    chk(cmd_request === 1'b0 && inhibit === 1'b1, "disabled");
    wr(8'h00, 32'h1, r);
    for (int i = 0; i < 2; i++) begin
      cmd(15'h0500 | (15'h1 << i), 30'h0, 2);
      span(i, SOUND_SIGNAL_STORE);
    end
    tube(8'h35, 13'h0020, 2'b10);
    tube(8'h4c, 13'h1000, 2'b01);
    cmd(15'h030d, 30'h0, 3);
    repeat (2) @(posedge aclk);
    #1;
    chk(cmd_request === 1'b1 && relay_sel === 13'h0, "bad relay");
    cmd(15'h06a5, 30'h0, 0);
    span(2, SEL);
    rd(8'h04, d, r);
    chk(d[7:0] === 8'ha5 && d[9] === 1'b0, "status");
    chk(status_mismatch_error === 1'b0 && launch_mismatch_error === 1'b0,
        "mismatch pins");
    cmd(15'h0335, 30'h100000, 0);
    span(3, CYC_PULSE);
    chk(relay_sel === 13'h0, "fault launched");
    cmd(15'h1335, 30'h0, 0);
    span(3, CYC_PULSE);
    cmd(15'h2000, 30'h0, 0);
    span(2, CYC_INTG_LOCK);
    chk(arm_interrogate_code === 3'h2, "query code");
    cmd(15'h4035, 30'h0, 0);
    span(2, SEL);
    chk(tube_interrogate_out === 1'b1 && relay_sel === 13'h0020
        && firing_select === 2'b00, "hold");
    cmd(15'h1035, 30'h0, 0);
    span(4, CYC_PULSE);
    upto(6);
    chk(arm_interrogate_code === 3'h1, "tube query");
    close_out;
  end
endmodule

bind redundant_launch_command_logic launch_cmd_monitor #(
  .TUBE_CYC(TUBE_CYC), .SUS_CYC(SUS_CYC), .FIRE_CYC(FIRE_CYC)
) u_launch_cmd_monitor (
  .aclk, .aresetn, .cmd_request, .inhibit, .type_one_error,
  .launch_mismatch_error, .arm_interrogate, .launch_cmd, .relay_sel,
  .tube_interrogate_out, .spare_out, .firing_select, .sus_deep,
  .sus_shallow);
